// *** core/rmr_report_port.sv ***
/*
  received-message report port: serialises decoded link messages into
  valid/kind/byte beats for user logic.
  assumes a link-side decoder presenting one-cycle message pulses, and a
  user that samples every valid beat, as there is no backpressure.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rmr_regs.svh"
// Functional notes
// - valid stays high consecutive cycles per message, length set by kind.
// - at least one low cycle between bursts of successive messages.
// - port reports nothing unless enabled as a static option.
// - each valid cycle carries one parameter byte, ordered by kind.
// - five-bit kind code driven while valid is high.
// - kind codes 0-20 as listed; 17 and 21-31 reserved.
// - error, intx, pm, unlock messages: two beats, bus then dev/func.
// - slot power limit: six beats, id then payload lsb first.
// - ltr: six beats, id, snoop low/high, no-snoop low/high.
// - vendor-defined: four beats bare, eight with data, id, vendor id, then payload.
module rmr_report_port
    import rmr_pkg::*;
#(
    parameter bit ENABLE = 1'b1
)
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire rmr_msg_s   msgIn,
    output logic            msgBusy,
    output rmr_rep_s        report
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        rmr_state_e state;
        rmr_msg_s   msg;
        logic [3:0] beat;
        logic [3:0] len;
        logic [3:0] gap;
        rmr_rep_s   rep;
    } rmr_core_s;

    rmr_core_s   st_r;
    rmr_core_s   st_nxt;
    logic [7:0]  selByte;
    logic [3:0]  selBeat;
    rmr_msg_s    selMsg;
    logic [3:0]  newLen;
    logic        accept;

    // ---------------------------------------------------------------
    // length per kind
    // ---------------------------------------------------------------
    always_comb
    begin
        newLen = 4'h0;
        if (msgIn.kind <= `RMR_KIND_LAST_PM || msgIn.kind == `RMR_KIND_UNLOCK)
            newLen = `RMR_LEN_SHORT;
        else if (msgIn.kind == `RMR_KIND_SSPL || msgIn.kind == `RMR_KIND_LTR)
            newLen = `RMR_LEN_LONG;
        else if (msgIn.kind == `RMR_KIND_VDM0 || msgIn.kind == `RMR_KIND_VDM1)
            newLen = msgIn.hasData ? `RMR_LEN_VDM_DAT : `RMR_LEN_VDM_NODAT;
        else
            newLen = 4'h0;                              // reserved kinds
    end

    assign accept = ENABLE && msgIn.valid && (newLen != 4'h0)
                    && (st_r.state == RMR_IDLE);
    assign msgBusy = (st_r.state != RMR_IDLE);

    // ---------------------------------------------------------------
    // byte select inputs
    // ---------------------------------------------------------------
    // built from the registered state, or from msgIn on accept, so the byte mux never loops back
    always_comb
    begin
        selMsg  = st_r.msg;
        selBeat = st_r.beat + 4'h1;
        if (accept)
        begin
            selMsg  = msgIn;
            selBeat = 4'h0;
        end
    end

    rmr_byte_sel u_sel
    (
        .beat    (selBeat),
        .msg     (selMsg),
        .byteOut (selByte)
    );

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rep.valid = 1'b0;
        unique case (st_r.state)
            RMR_IDLE:
            begin
                if (accept)
                begin
                    st_nxt.state = RMR_SEND;
                    st_nxt.msg   = msgIn;
                    st_nxt.beat  = 4'h0;
                    st_nxt.len   = newLen;
                end
            end
            RMR_SEND:
            begin
                if (st_r.beat == st_r.len - 4'h1)
                begin
                    st_nxt.state = RMR_GAP;
                    st_nxt.gap   = `RMR_MIN_GAP;
                end
                else
                begin
                    st_nxt.beat = st_r.beat + 4'h1;
                end
            end
            RMR_GAP:
            begin
                if (st_r.gap > 4'h1)
                begin
                    st_nxt.gap = st_r.gap - 4'h1;
                end
                else
                begin
                    st_nxt.state = RMR_IDLE;
                end
            end
            default:
            begin
                st_nxt.state = RMR_IDLE;
            end
        endcase
        if (st_nxt.state == RMR_SEND)
        begin
            st_nxt.rep.valid = 1'b1;
            st_nxt.rep.kind  = st_nxt.msg.kind;
            st_nxt.rep.data  = selByte;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '{state: RMR_IDLE, default: '0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign report = st_r.rep;
endmodule
`default_nettype wire

// *** core/rmr_regs.svh ***
/*
  timing and encoding constants of the received-message report port.
  assumes inclusion by bare name from the package.
*/
`ifndef RMR_REGS_SVH
`define RMR_REGS_SVH

`define RMR_LEN_SHORT     4'h2
`define RMR_LEN_LONG      4'h6
`define RMR_LEN_VDM_NODAT 4'h4
`define RMR_LEN_VDM_DAT   4'h8
`define RMR_MIN_GAP       4'h1
`define RMR_KIND_LAST_ERR 5'h02
`define RMR_KIND_LAST_PM  5'h0e
`define RMR_KIND_SSPL     5'h0f
`define RMR_KIND_LTR      5'h10
`define RMR_KIND_RSVD17   5'h11
`define RMR_KIND_UNLOCK   5'h12
`define RMR_KIND_VDM0     5'h13
`define RMR_KIND_VDM1     5'h14

`endif

// *** core/rmr_pkg.sv ***
/*
  types of the received-message report port.
  assumes rmr_regs.svh on the include path.
*/
`include "rmr_regs.svh"
package rmr_pkg;
    typedef logic [4:0] rmr_kind_t;

    // decoded message handed in by the link-side decoder
    typedef struct packed {
        logic        valid;
        rmr_kind_t   kind;
        logic [15:0] reqId;
        logic [15:0] vendorId;
        logic [31:0] payload;
        logic        hasData;
    } rmr_msg_s;

    // report toward the user
    typedef struct packed {
        logic        valid;
        rmr_kind_t   kind;
        logic [7:0]  data;
    } rmr_rep_s;

    typedef enum logic [2:0] {
        RMR_IDLE = 3'b001,
        RMR_SEND = 3'b010,
        RMR_GAP  = 3'b100
    } rmr_state_e;
endpackage

// *** core/rmr_byte_sel.sv ***
/*
  picks the parameter byte for a given beat of a message.
  assumes a captured message and beat index from the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rmr_regs.svh"
module rmr_byte_sel
    import rmr_pkg::*;
(
    input  wire logic [3:0] beat,
    input  wire rmr_msg_s   msg,
    output logic [7:0]      byteOut
);
    logic isVdm;

    assign isVdm = (msg.kind == `RMR_KIND_VDM0) || (msg.kind == `RMR_KIND_VDM1);

    always_comb
    begin
        byteOut = 8'h00;
        unique case (beat)
            4'h0: byteOut = msg.reqId[15:8];
            4'h1: byteOut = msg.reqId[7:0];
            // ltr payload packs snoop in the low half, no-snoop in the high half
            4'h2: byteOut = isVdm ? msg.vendorId[7:0]  : msg.payload[7:0];
            4'h3: byteOut = isVdm ? msg.vendorId[15:8] : msg.payload[15:8];
            4'h4: byteOut = isVdm ? msg.payload[7:0]   : msg.payload[23:16];
            4'h5: byteOut = isVdm ? msg.payload[15:8]  : msg.payload[31:24];
            4'h6: byteOut = msg.payload[23:16];
            4'h7: byteOut = msg.payload[31:24];
            default: byteOut = 8'h00;
        endcase
    end
endmodule
`default_nettype wire

// *** sim/rmr_report_monitor.sv ***
/* assertions on the report port.
   assumes binding to rmr_report_port. */
`timescale 1ns/1ps
`default_nettype none
module rmr_report_monitor
    import rmr_pkg::*;
#(
    parameter bit ENABLE = 1'b1
)
(
    input wire logic     clk,
    input wire logic     rst_n,
    input wire rmr_msg_s msgIn,
    input wire logic     msgBusy,
    input wire rmr_rep_s report
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic       take = ENABLE && msgIn.valid && !msgBusy;
    wire logic [4:0] k = msgIn.kind;
    a_gap_after_burst: assert property ($fell(report.valid) |=> !report.valid)
        else $error("gap short");
    a_kind_steady: assert property (report.valid && $past(report.valid) |-> $stable(report.kind))
        else $error("kind moved");
    a_off_silent: assert property (!ENABLE |-> !report.valid && !msgBusy)
        else $error("disabled port active");
    a_first_byte: assert property (take && (k < 5'h11 || (k > 5'h11 && k < 5'h15)) |=>
        report.valid &&
        report.kind == $past(k) && report.data == $past(msgIn.reqId[15:8])) else $error("beat0");
    a_short_len: assert property (take && (k < 5'h0f || k == 5'h12) |=>
        report.valid[*2] ##1 !report.valid) else $error("short len");
    a_long_len: assert property (take && (k == 5'h0f || k == 5'h10) |=>
        report.valid[*6] ##1 !report.valid) else $error("long len");
    a_vdm_bare: assert property (take && (k == 5'h13 || k == 5'h14) && !msgIn.hasData |=>
        report.valid[*4] ##1 !report.valid) else $error("vdm len");
    a_vdm_data: assert property (take && (k == 5'h13 || k == 5'h14) && msgIn.hasData |=>
        report.valid[*8] ##1 !report.valid) else $error("vdm data len");
    a_rsvd_drop: assert property (take && (k == 5'h11 || k > 5'h14) |=> !report.valid)
        else $error("reserved seen");
    cover property (take && k == 5'h0f);
    cover property (take && k == 5'h14 && msgIn.hasData);
    cover property (msgIn.valid && msgBusy);
endmodule
bind rmr_report_port rmr_report_monitor #(.ENABLE(ENABLE)) mon_u (.clk(clk), .rst_n(rst_n),
    .msgIn(msgIn),
    .msgBusy(msgBusy), .report(report));
`default_nettype wire

// *** sim/rmr_user_sink.sv ***
/* user-side sink: samples every valid beat.
   assumes the report port's clock. */
`timescale 1ns/1ps
`default_nettype none
module rmr_user_sink
    import rmr_pkg::*;
(
    input wire logic     clk,
    input wire rmr_rep_s report
);
    logic [12:0] beats[$];
    always @(posedge clk)
        if (report.valid) beats.push_back({report.kind, report.data});
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
/* self-checking bench for the report port.
   assumes the package, the sink and the bound monitor. */
`timescale 1ns/1ps
`default_nettype none
module testbench
    import rmr_pkg::*;
();
    logic     clk = 1'b0;
    logic     rst_n = 1'b0;
    rmr_msg_s msgIn = '0;
    logic     msgBusy;
    rmr_rep_s report;
    logic     offBusy;
    rmr_rep_s offReport;
    int       fails = 0;
    int       checks = 0;
    initial forever #20 clk = ~clk;
    rmr_report_port #(.ENABLE(1'b1)) dut_u (.clk(clk), .rst_n(rst_n), .msgIn(msgIn),
        .msgBusy(msgBusy), .report(report));
    rmr_report_port #(.ENABLE(1'b0)) off_u (.clk(clk), .rst_n(rst_n), .msgIn(msgIn),
        .msgBusy(offBusy), .report(offReport));
    rmr_user_sink sink_u (.clk(clk), .report(report));
    task automatic tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one message, optional second pulse while busy; n expected beats
    task automatic msg(input logic [4:0] k, input logic hd, input int n, input logic dup);
        logic [63:0] e;
        int          i;
        e = (k > 5'h12) ? 64'h5a3c_1122_5566_7788 : 64'h5a3c_5566_7788_0000;
        sink_u.beats.delete();
        msgIn = '{1'b1, k, 16'h5a3c, 16'h2211, 32'h8877_6655, hd};
        @(negedge clk);
        checks++;
        if (msgBusy !== (n != 0))
        begin
            fails++;
            $display("wrong value busy expected %0d seen %0d", n != 0, msgBusy);
        end
        msgIn.valid = dup;
        msgIn.kind = 5'h00;
        @(negedge clk);
        msgIn.valid = 1'b0;
        for (i = 0; i < 20 && msgBusy !== 1'b0; i++)
            @(negedge clk);
        checks++;
        if (sink_u.beats.size() != n)
        begin
            fails++;
            $display("wrong value count %h expected %0d seen %0d", k, n, sink_u.beats.size());
        end
        for (i = 0; i < n && i < sink_u.beats.size(); i++)
        begin
            checks++;
            if (sink_u.beats[i] !== {k, e[63-8*i -: 8]})
            begin
                fails++;
                $display("wrong value beat expected %h seen %h", {k, e[63-8*i -: 8]}, sink_u.beats[i]);
            end
        end
    endtask
    task automatic test_short;
        for (int k = 0; k < 15; k++)
            msg(k[4:0], 1'b0, 2, 1'b0);
        msg(5'h12, 1'b0, 2, 1'b0);
        $display("short kinds done");
    endtask
    task automatic test_long;
        msg(5'h0f, 1'b0, 6, 1'b1);
        msg(5'h10, 1'b0, 6, 1'b0);
        msg(5'h13, 1'b0, 4, 1'b0);
        msg(5'h13, 1'b1, 8, 1'b0);
        msg(5'h14, 1'b0, 4, 1'b0);
        msg(5'h14, 1'b1, 8, 1'b1);
        $display("long kinds done");
    endtask
    task automatic test_reserved;
        for (int k = 17; k < 32; k++)
            if (k == 17 || k > 20)
                msg(k[4:0], 1'b0, 0, 1'b0);
        $display("reserved kinds done");
    endtask
    task automatic test_disabled;
        int i;
        msgIn = '{1'b1, 5'h0f, 16'h5a3c, 16'h2211, 32'h8877_6655, 1'b0};
        for (i = 0; i < 12; i++)
        begin
            @(negedge clk);
            msgIn.valid = 1'b0;
            checks++;
            if (offReport.valid !== 1'b0 || offBusy !== 1'b0)
            begin
                fails++;
                $display("wrong value disabled port expected 0 seen %b", offReport.valid | offBusy);
            end
        end
        $display("disabled port done");
    endtask
    task automatic test_reset;
        msgIn = '{1'b1, 5'h10, 16'h5a3c, 16'h2211, 32'h8877_6655, 1'b0};
        @(negedge clk);
        msgIn.valid = 1'b0;
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        checks++;
        if (report !== '0 || msgBusy !== 1'b0)
        begin
            fails++;
            $display("wrong value reset report expected 0 seen %h", report);
        end
        rst_n = 1'b1;
        msg(5'h00, 1'b0, 2, 1'b0);
        $display("reset recovery done");
    endtask
    initial
    begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        test_short();
        test_long();
        test_reserved();
        test_disabled();
        test_reset();
        tally_and_finish();
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
